// ===== core/evhp_bus_if.sv
`timescale 1ns/1ps
// Shared host bus, streams and link clock between the two ends
interface evhp_bus_if;
  import evhp_pkg::*;
  logic serial_shift_clock;
  logic frame_pulse_in;
  logic stream_output_gate;
  logic freq_sel;
  logic host_strobe_n;
  logic select_n;
  logic rd_wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_h;
  logic data_h_oe;
  logic [DATA_W-1:0] data_d;
  logic data_d_oe;
  logic ack_oe;
  logic irq_oe;
  logic rin;
  logic sin;
  logic rout_d;
  logic rout_oe;
  logic sout_d;
  logic sout_oe;
  // Resolved wire levels, pull-ups on open-drain and idle lines
  logic [DATA_W-1:0] data;
  logic transfer_ack_n;
  logic irq_n;
  logic rout;
  logic sout;
  assign data = data_d_oe ? data_d : (data_h_oe ? data_h : BUS_IDLE);
  assign transfer_ack_n = ~ack_oe;
  assign irq_n = ~irq_oe;
  assign rout = rout_oe ? rout_d : 1'b1;
  assign sout = sout_oe ? sout_d : 1'b1;

  modport dev (
    input serial_shift_clock, frame_pulse_in, stream_output_gate,
    input freq_sel, host_strobe_n, select_n, rd_wr, addr, data,
    input rin, sin,
    output data_d, data_d_oe, ack_oe, irq_oe,
    output rout_d, rout_oe, sout_d, sout_oe
  );
  modport host (
    output serial_shift_clock, frame_pulse_in, stream_output_gate,
    output freq_sel, host_strobe_n, select_n, rd_wr, addr,
    output data_h, data_h_oe, rin, sin,
    input data, transfer_ack_n, irq_n, rout, sout
  );
endinterface

// ===== core/evhp_device.sv
`timescale 1ns/1ps
// Voice processor end: host port on CLOCK, streams on the link clock
module evhp_device
  import evhp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  evhp_bus_if.dev BUS,
  input wire logic EVENT_VALID,
  input wire logic [EVT_W-1:0] EVENT_CHAN,
  output logic EVENT_READY,
  output logic MCLK_10MHZ,
  output logic FRAME_TICK,
  output logic FMT_ACTIVE_HIGH,
  output logic [DATA_W-1:0] MAIN_CTRL
);
  localparam int SYN_W = 3 + ADDR_W + DATA_W;

  // ************************************************************
  // Pin synchronisers on the master clock
  // ************************************************************
  logic [SYN_W-1:0] pin_raw, pin_s1, pin_s2;
  logic strobe_n_s, select_n_s, rd_wr_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic fsel_s1, fsel_s2;

  assign pin_raw = {BUS.host_strobe_n, BUS.select_n, BUS.rd_wr,
                    BUS.addr, BUS.data};
  assign {strobe_n_s, select_n_s, rd_wr_s, addr_s, data_s} = pin_s2;

  // Two flops per bus pin
  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_pin_sync
      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  // Frequency select sampled to report the master clock rate
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      fsel_s1 <= 1'b0;
      fsel_s2 <= 1'b0;
      MCLK_10MHZ <= 1'b0;
    end else begin
      fsel_s1 <= BUS.freq_sel;
      fsel_s2 <= fsel_s1;
      MCLK_10MHZ <= (fsel_s2 == FSEL_10MHZ); // see RULE7
    end
  end

  // ************************************************************
  // Interrupt event FIFO
  // ************************************************************
  logic evt_valid;
  logic evt_pop;
  logic [EVT_W-1:0] evt_data;

  evhp_fifo #(.WIDTH(EVT_W), .DEPTH(FIFO_DEPTH)) u_evt_fifo (
    .clk(CLOCK),
    .rst_b(RST_B),
    .in_valid(EVENT_VALID),
    .in_ready(EVENT_READY),
    .in_data(EVENT_CHAN),
    .out_valid(evt_valid),
    .out_ready(evt_pop),
    .out_data(evt_data)
  );

  // Interrupt line held while entries remain
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      BUS.irq_oe <= 1'b0;
    end else begin
      BUS.irq_oe <= evt_valid; // see RULE9 see RULE10
    end
  end

  // ************************************************************
  // Host access state machine
  // ************************************************************
  evhp_dev_state_t state;
  logic access;
  logic [DATA_W-1:0] rd_value;
  logic [DATA_W-1:0] status;
  logic fmt_m;

  assign access = !strobe_n_s && !select_n_s; // see RULE1 see RULE11
  assign evt_pop = (state == DEV_IDLE) && access && rd_wr_s &&
                   (addr_s == IRQ_FIFO_ADDR) && evt_valid;
  assign status = {5'h00, fmt_m, MCLK_10MHZ, evt_valid};

  // Read data selection
  always_comb begin
    rd_value = EMPTY_READ;
    case (addr_s) // see RULE13
      MAIN_CTRL_ADDR: rd_value = MAIN_CTRL;
      IRQ_FIFO_ADDR: rd_value = evt_valid ? {1'b1, evt_data} : EMPTY_READ;
      STATUS_ADDR: rd_value = status;
      default: rd_value = EMPTY_READ;
    endcase
  end

  // Handshake, data drive and acknowledge
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= DEV_IDLE;
      BUS.ack_oe <= 1'b0;
      BUS.data_d_oe <= 1'b0;
      BUS.data_d <= '0;
    end else begin
      case (state)
        DEV_IDLE: begin
          if (access) begin
            state <= DEV_ACK;
            BUS.ack_oe <= 1'b1; // see RULE3
            BUS.data_d_oe <= rd_wr_s; // see RULE2 see RULE12
            BUS.data_d <= rd_value;
          end
        end
        DEV_ACK: begin
          if (!access) begin
            state <= DEV_IDLE;
            BUS.ack_oe <= 1'b0; // see RULE15
            BUS.data_d_oe <= 1'b0;
          end
        end
        default: state <= DEV_IDLE;
      endcase
    end
  end

  // Main control register write
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      MAIN_CTRL <= MAIN_CTRL_RST;
    end else if (state == DEV_IDLE && access && !rd_wr_s &&
                 addr_s == MAIN_CTRL_ADDR) begin
      MAIN_CTRL <= data_s; // see RULE2
    end
  end

  // ************************************************************
  // Link clock domain: frame detect and stream drive
  // ************************************************************
  logic lrst_s1, link_rst_b;
  logic [3:0] lpin_raw, lpin_s1, lpin_s2;
  logic gate_s1, gate_s2;
  logic fp, fp_prev, idle_lvl, idle_known, frame_start, frame_tog;
  logic [$clog2(IDLE_RUN)-1:0] run;
  logic [FCNT_W-1:0] fcnt;

  assign lpin_raw = {BUS.stream_output_gate, BUS.frame_pulse_in,
                     BUS.rin, BUS.sin};
  assign fp = lpin_s2[2];
  assign frame_start = idle_known && fp != idle_lvl && fp_prev == idle_lvl;

  // Reset release aligned to the link clock
  always_ff @(posedge BUS.serial_shift_clock or negedge RST_B) begin
    if (!RST_B) begin
      lrst_s1 <= 1'b0;
      link_rst_b <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      link_rst_b <= lrst_s1;
    end
  end

  // Two flops per link pin
  generate
    for (gi = 0; gi < 4; gi++) begin : g_link_sync
      always_ff @(posedge BUS.serial_shift_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
          lpin_s1[gi] <= 1'b0;
          lpin_s2[gi] <= 1'b0;
        end else begin
          lpin_s1[gi] <= lpin_raw[gi];
          lpin_s2[gi] <= lpin_s1[gi];
        end
      end
    end
  endgenerate

  // Idle level learnt from a steady run; the pulse is the other level
  always_ff @(posedge BUS.serial_shift_clock or negedge link_rst_b) begin
    if (!link_rst_b) begin
      fp_prev <= 1'b0;
      run <= '0;
      idle_lvl <= 1'b1;
      idle_known <= 1'b0;
    end else begin
      fp_prev <= fp;
      if (fp != fp_prev) begin
        run <= '0;
      end else if (run != $clog2(IDLE_RUN)'(IDLE_RUN - 1)) begin
        run <= run + 1'b1;
      end else begin
        idle_lvl <= fp; // see RULE5
        idle_known <= 1'b1;
      end
    end
  end

  // Link clock position within the frame, frame event toggle
  always_ff @(posedge BUS.serial_shift_clock or negedge link_rst_b) begin
    if (!link_rst_b) begin
      fcnt <= '0;
      frame_tog <= 1'b0;
    end else if (frame_start) begin
      fcnt <= '0; // see RULE14
      frame_tog <= ~frame_tog;
    end else begin
      fcnt <= fcnt + 1'b1; // see RULE6
    end
  end

  // Output gate: pin and control bit, both crossed in
  always_ff @(posedge BUS.serial_shift_clock or negedge link_rst_b) begin
    if (!link_rst_b) begin
      gate_s1 <= 1'b0;
      gate_s2 <= 1'b0;
      BUS.rout_oe <= 1'b0;
      BUS.sout_oe <= 1'b0;
      BUS.rout_d <= 1'b1;
      BUS.sout_d <= 1'b1;
    end else begin
      gate_s1 <= MAIN_CTRL[GATE_BIT];
      gate_s2 <= gate_s1;
      BUS.rout_oe <= gate_s2 & lpin_s2[3]; // see RULE4
      BUS.sout_oe <= gate_s2 & lpin_s2[3]; // see RULE4
      BUS.rout_d <= lpin_s2[1]; // see RULE6
      BUS.sout_d <= lpin_s2[0];
    end
  end

  // ************************************************************
  // Frame timing back to the master clock
  // ************************************************************
  logic tog_s1, tog_s2, tog_s3, fmt_s1;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      fmt_s1 <= 1'b0;
      fmt_m <= 1'b0;
      FRAME_TICK <= 1'b0;
      FMT_ACTIVE_HIGH <= 1'b0;
    end else begin
      tog_s1 <= frame_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      FRAME_TICK <= tog_s2 ^ tog_s3; // see RULE8
      fmt_s1 <= ~idle_lvl;
      fmt_m <= fmt_s1;
      FMT_ACTIVE_HIGH <= fmt_m; // see RULE5
    end
  end
endmodule

// ===== core/evhp_fifo.sv
`timescale 1ns/1ps
// Small flip-flop FIFO with registered full and empty
module evhp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic [IW:0] count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_idx];

  // Storage and pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_idx <= '0;
      rd_idx <= '0;
    end else begin
      if (push) begin
        mem[wr_idx] <= in_data;
        wr_idx <= (wr_idx == IW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == IW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
    end
  end

  // Occupancy with registered flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (push != pop) begin
      count <= push ? count + 1'b1 : count - 1'b1;
      in_ready <= !(push && count == (IW+1)'(DEPTH - 1));
      out_valid <= push || count != (IW+1)'(1);
    end
  end
endmodule

// ===== core/evhp_host.sv
`timescale 1ns/1ps
// Host end: strobed bus master, serial clock and frame pulse source
module evhp_host
  import evhp_pkg::*;
#(
  parameter int HALF_DIV = SCLK_HALF,
  parameter bit FRAME_HIGH = 1'b0
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  evhp_bus_if.host BUS,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W-1:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [DATA_W-1:0] RSP_RDATA,
  input wire logic GATE_REQ,
  input wire logic SLOW_MCLK,
  input wire logic RIN_BIT,
  input wire logic SIN_BIT,
  output logic IRQ,
  output logic ROUT_BIT,
  output logic SOUT_BIT
);
  localparam int SYN_W = 4 + DATA_W;
  localparam int DW = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;

  // ************************************************************
  // Synchronisers for lines the device drives
  // ************************************************************
  logic [SYN_W-1:0] in_raw;
  logic [SYN_W-1:0] in_s1;
  logic [SYN_W-1:0] in_s2;
  logic ack_n_s;
  logic [DATA_W-1:0] data_s;

  assign in_raw = {BUS.transfer_ack_n, BUS.irq_n, BUS.rout, BUS.sout,
                   BUS.data};
  assign ack_n_s = in_s2[SYN_W-1];
  assign data_s = in_s2[DATA_W-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          in_s1[gi] <= 1'b1;
          in_s2[gi] <= 1'b1;
        end else begin
          in_s1[gi] <= in_raw[gi];
          in_s2[gi] <= in_s1[gi];
        end
      end
    end
  endgenerate

  // User side copies of interrupt and streams
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
      ROUT_BIT <= 1'b1;
      SOUT_BIT <= 1'b1;
    end else begin
      IRQ <= ~in_s2[SYN_W-2]; // see RULE9
      ROUT_BIT <= in_s2[SYN_W-3];
      SOUT_BIT <= in_s2[SYN_W-4];
    end
  end

  // ************************************************************
  // Bus master state machine
  // ************************************************************
  evhp_host_state_t state;
  logic is_read;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state <= HST_IDLE;
      is_read <= 1'b0;
      REQ_READY <= 1'b1;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
      BUS.select_n <= 1'b1;
      BUS.host_strobe_n <= 1'b1;
      BUS.rd_wr <= 1'b1;
      BUS.addr <= '0;
      BUS.data_h <= '0;
      BUS.data_h_oe <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state)
        HST_IDLE: begin
          if (REQ_VALID && REQ_READY) begin
            state <= HST_SETUP;
            REQ_READY <= 1'b0;
            is_read <= !REQ_WRITE;
            BUS.select_n <= 1'b0; // see RULE11
            BUS.rd_wr <= !REQ_WRITE; // see RULE2
            BUS.addr <= REQ_ADDR; // see RULE13
            BUS.data_h <= REQ_WDATA;
            BUS.data_h_oe <= REQ_WRITE; // see RULE12
          end
        end
        HST_SETUP: begin
          state <= HST_STROBE;
          BUS.host_strobe_n <= 1'b0; // see RULE1
        end
        HST_STROBE: begin
          if (!ack_n_s) begin
            state <= HST_RELEASE;
            BUS.host_strobe_n <= 1'b1;
            BUS.select_n <= 1'b1;
            BUS.data_h_oe <= 1'b0;
            RSP_VALID <= is_read;
            RSP_RDATA <= data_s;
          end
        end
        HST_RELEASE: begin
          if (ack_n_s) begin
            state <= HST_IDLE; // see RULE15
            REQ_READY <= 1'b1;
          end
        end
        default: state <= HST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Serial clock, frame pulse and input streams
  // ************************************************************
  logic [DW-1:0] div;
  logic [FCNT_W:0] half_cnt;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      div <= '0;
      half_cnt <= '0;
      BUS.serial_shift_clock <= 1'b0;
      BUS.frame_pulse_in <= !FRAME_HIGH;
      BUS.rin <= 1'b1;
      BUS.sin <= 1'b1;
      BUS.stream_output_gate <= 1'b0;
      BUS.freq_sel <= 1'b0;
    end else begin
      BUS.stream_output_gate <= GATE_REQ;
      BUS.freq_sel <= SLOW_MCLK; // see RULE7
      if (div == DW'(HALF_DIV - 1)) begin
        div <= '0;
        BUS.serial_shift_clock <= ~BUS.serial_shift_clock; // see RULE6
        half_cnt <= half_cnt + 1'b1; // see RULE14
        if (BUS.serial_shift_clock) begin
          BUS.frame_pulse_in <= (half_cnt[FCNT_W:1] == '0) ? FRAME_HIGH
                                                          : !FRAME_HIGH;
          BUS.rin <= RIN_BIT;
          BUS.sin <= SIN_BIT;
        end
      end else begin
        div <= div + 1'b1;
      end
    end
  end
endmodule

// ===== core/evhp_pkg.sv
// Summary of operation
// RULE1: Access only while strobe and select low
// RULE2: Host sets direction; device drives data on reads
// RULE3: Acknowledge pulled low when transfer completes
// RULE4: Streams driven only when pin and bit6 high
// RULE5: Frame pulse format detected automatically
// RULE6: Streams shifted on system serial clock
// RULE7: Frequency select picks 20 or 10 MHz
// RULE8: Master clock resynchronised to frame timing
// RULE9: Interrupt pulled low on any channel event
// RULE10: Interrupt released once FIFO fully read
// RULE11: Respond only while own select asserted
// RULE12: Eight-bit shared bidirectional data bus
// RULE13: Thirteen shared address inputs
// RULE14: 32 channels per frame at 2.048 Mb/s
// RULE15: Acknowledge released after strobe or select drops
package evhp_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int EVT_W = 7;
  localparam int FIFO_DEPTH = 4;
  localparam int CHANNELS = 32;
  localparam int BITS_PER_CHAN = 8;
  localparam int CLK_PER_BIT = 2;
  localparam int CLK_PER_FRAME = CHANNELS * BITS_PER_CHAN * CLK_PER_BIT;
  localparam int FCNT_W = $clog2(CLK_PER_FRAME);
  localparam int IDLE_RUN = 8;
  // Register map
  localparam logic [ADDR_W-1:0] MAIN_CTRL_ADDR = 13'h0000;
  localparam logic [ADDR_W-1:0] IRQ_FIFO_ADDR = 13'h0001;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 13'h0002;
  localparam int GATE_BIT = 6;
  localparam logic [DATA_W-1:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] EMPTY_READ = 8'h00;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;
  // Frequency select level for the slow master clock
  localparam logic FSEL_10MHZ = 1'b1;
  // Host side serial clock divider, half period in CLOCK cycles
  localparam int SCLK_HALF = 1;

  typedef enum logic [0:0] {DEV_IDLE, DEV_ACK} evhp_dev_state_t;
  typedef enum logic [1:0] {
    HST_IDLE, HST_SETUP, HST_STROBE, HST_RELEASE
  } evhp_host_state_t;
endpackage

// ===== verif/echo_processor_host_port_tb.sv
`timescale 1ns/1ps
module echo_processor_host_port_tb
  import evhp_pkg::*;
;
  logic clock, rst_b, ev_valid, ev_ready, mclk10, frame_tick, fmt_high;
  logic req_valid, req_write, req_ready, rsp_valid, gate_req, slow_mclk;
  logic rin_bit, sin_bit, irq, rout_bit, sout_bit, mclk_exp, e;
  logic [EVT_W-1:0] ev_chan;
  logic [ADDR_W-1:0] req_addr, a;
  logic [DATA_W-1:0] main_ctrl, req_wdata, rsp_rdata, exp_main;
  logic [DATA_W-1:0] evq[$];
  logic [31:0] seed;
  int n_errors, tests_run, cycles, n;

  evhp_bus_if evhp_bus_if_i ();
  evhp_device evhp_device_i (.CLOCK(clock), .RST_B(rst_b),
    .BUS(evhp_bus_if_i), .EVENT_VALID(ev_valid), .EVENT_CHAN(ev_chan),
    .EVENT_READY(ev_ready), .MCLK_10MHZ(mclk10), .FRAME_TICK(frame_tick),
    .FMT_ACTIVE_HIGH(fmt_high), .MAIN_CTRL(main_ctrl));
  evhp_host #(.HALF_DIV(SCLK_HALF), .FRAME_HIGH(1'b1)) evhp_host_i (
    .CLOCK(clock), .RST_B(rst_b), .BUS(evhp_bus_if_i),
    .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .GATE_REQ(gate_req), .SLOW_MCLK(slow_mclk),
    .RIN_BIT(rin_bit), .SIN_BIT(sin_bit), .IRQ(irq), .ROUT_BIT(rout_bit),
    .SOUT_BIT(sout_bit));
  evhp_bus_properties evhp_bus_properties_i (.CLOCK(clock), .RST_B(rst_b),
    .serial_shift_clock(evhp_bus_if_i.serial_shift_clock),
    .stream_output_gate(evhp_bus_if_i.stream_output_gate),
    .host_strobe_n(evhp_bus_if_i.host_strobe_n),
    .select_n(evhp_bus_if_i.select_n), .rd_wr(evhp_bus_if_i.rd_wr),
    .addr(evhp_bus_if_i.addr), .data_d_oe(evhp_bus_if_i.data_d_oe),
    .ack_oe(evhp_bus_if_i.ack_oe), .irq_oe(evhp_bus_if_i.irq_oe),
    .rout_oe(evhp_bus_if_i.rout_oe), .sout_oe(evhp_bus_if_i.sout_oe));

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [DATA_W-1:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One host transfer through the request handshake
  task automatic access(input logic wr, input logic [ADDR_W-1:0] ad,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r);
    int k;
    k = 0;
    do @(negedge clock); while (!req_ready && ++k < 300);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= ad;
    req_wdata <= d;
    @(posedge clock);
    req_valid <= 1'b0;
    k = 0;
    do @(negedge clock); while (!(wr ? req_ready : rsp_valid) && ++k < 300);
    r = rsp_rdata;
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] ad, input logic [7:0] d);
    logic [DATA_W-1:0] r;
    access(1'b1, ad, d, r);
    if (ad == MAIN_CTRL_ADDR) exp_main = d;
  endtask

  // Read with the expected value from the bench model
  task automatic rd_chk(input logic [ADDR_W-1:0] ad);
    logic [DATA_W-1:0] r, w;
    w = EMPTY_READ;
    if (ad == MAIN_CTRL_ADDR) w = exp_main;
    else if (ad == STATUS_ADDR) w = {5'h00, 1'b1, mclk_exp, evq.size() != 0};
    else if (ad == IRQ_FIFO_ADDR && evq.size() != 0) w = evq.pop_front();
    access(1'b0, ad, 8'h00, r);
    chk(r, w);
  endtask

  task automatic push_evt(input logic [EVT_W-1:0] c);
    logic rdy;
    @(negedge clock);
    rdy = ev_ready;
    chk({7'h00, rdy}, {7'h00, evq.size() < FIFO_DEPTH});
    @(posedge clock);
    ev_valid <= 1'b1;
    ev_chan <= c;
    @(posedge clock);
    ev_valid <= 1'b0;
    if (rdy) evq.push_back({1'b1, c});
  endtask

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      give_verdict;
    end
  end

  initial begin
    {rst_b, ev_valid, ev_chan, req_valid, req_write} = '0;
    {req_addr, req_wdata, gate_req, slow_mclk, rin_bit, sin_bit} = '0;
    seed = 32'h72A0;
    exp_main = MAIN_CTRL_RST;
    mclk_exp = 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk(main_ctrl, MAIN_CTRL_RST);
    chk({7'h00, irq}, 8'h00);
    // Frame pulses: polarity learnt, one tick each 1024 clocks
    repeat (2100) @(posedge clock);
    n = 0;
    repeat (3072) begin
      @(negedge clock);
      n += frame_tick;
    end
    chk(n[7:0], 8'h03);
    chk({7'h00, fmt_high}, 8'h01);
    // Random back to back traffic, unmapped places included
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      a = (seed[4:2] == 3'h7) ? seed[31:19] : {11'h000, seed[1:0]};
      if (seed[5]) wr_reg(a, seed[15:8]);
      else rd_chk(a);
    end
    // Frequency select both ways
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      slow_mclk <= v[0];
      mclk_exp = (v[0] == FSEL_10MHZ);
      repeat (10) @(posedge clock);
      chk({7'h00, mclk10}, {7'h00, mclk_exp});
      rd_chk(STATUS_ADDR);
    end
    // Fill the event FIFO past full, then drain it
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      push_evt(seed[6:0]);
    end
    repeat (6) @(posedge clock);
    chk({7'h00, irq}, 8'h01);
    rd_chk(STATUS_ADDR);
    for (int i = 0; i < 5; i++) begin
      rd_chk(IRQ_FIFO_ADDR);
      repeat (6) @(posedge clock);
      chk({7'h00, irq}, {7'h00, evq.size() != 0});
    end
    // Stream gating over all pin and control bit combinations
    for (int g = 0; g < 4; g++) begin
      seed = xs(seed);
      wr_reg(MAIN_CTRL_ADDR, {1'b0, g[1], 6'h00});
      @(posedge clock);
      gate_req <= g[0];
      rin_bit <= seed[0];
      sin_bit <= seed[1];
      repeat (40) @(posedge clock);
      e = g[0] & g[1];
      chk({6'h00, rout_bit, sout_bit},
        {6'h00, e ? seed[0] : 1'b1, e ? seed[1] : 1'b1});
      chk(main_ctrl, exp_main);
    end
    // Second reset in mid-run
    @(posedge clock);
    rst_b <= 1'b0;
    gate_req <= 1'b0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    exp_main = MAIN_CTRL_RST;
    evq.delete();
    rd_chk(MAIN_CTRL_ADDR);
    give_verdict;
  end
endmodule

// ===== verif/evhp_bus_properties.sv
`timescale 1ns/1ps
// ************************************************************
// Bus and stream checks between the two ends
// ************************************************************
module evhp_bus_properties
  import evhp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic serial_shift_clock,
  input wire logic stream_output_gate,
  input wire logic host_strobe_n,
  input wire logic select_n,
  input wire logic rd_wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic data_d_oe,
  input wire logic ack_oe,
  input wire logic irq_oe,
  input wire logic rout_oe,
  input wire logic sout_oe
);
  // Acknowledged read of the interrupt FIFO
  logic fifo_read;
  assign fifo_read = ack_oe && rd_wr && (addr == IRQ_FIFO_ADDR);

  // Both access lines asserted
  sequence s_access;
    !host_strobe_n && !select_n;
  endsequence
  // Strobe falls while selected
  sequence s_start;
    $fell(host_strobe_n) && !select_n;
  endsequence

  property p_ack_cause;
    @(posedge CLOCK) disable iff (!RST_B) $rose(ack_oe) |-> s_access;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("Acknowledge without strobe and select");

  property p_ack_answer;
    @(posedge CLOCK) disable iff (!RST_B) s_start |-> ##[1:4] ack_oe;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("Acknowledge late");

  property p_ack_stands;
    @(posedge CLOCK) disable iff (!RST_B) (ack_oe and s_access) |=> ack_oe;
  endproperty
  a_ack_stands: assert property (p_ack_stands)
    else $error("Acknowledge dropped early");

  property p_ack_release;
    @(posedge CLOCK) disable iff (!RST_B)
      $rose(host_strobe_n) |-> ##[1:4] !ack_oe;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("Acknowledge not released");

  property p_read_drive;
    @(posedge CLOCK) disable iff (!RST_B)
      (ack_oe && rd_wr |-> data_d_oe) and (data_d_oe |-> rd_wr);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("Data drive does not match direction");

  property p_idle_quiet;
    @(posedge CLOCK) disable iff (!RST_B)
      select_n [*4] |-> !ack_oe && !data_d_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("Device drives while not selected");

  property p_irq_release;
    @(posedge CLOCK) disable iff (!RST_B)
      $fell(irq_oe) |-> $past(fifo_read) || $past(fifo_read, 2);
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("Interrupt released without FIFO read");

  property p_gate_off;
    @(posedge serial_shift_clock) disable iff (!RST_B)
      !stream_output_gate [*4] |-> !rout_oe && !sout_oe;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("Streams driven while gate pin low");

  // Enable needs the gate pin seen high two or three link edges back
  property p_oe_pair;
    @(posedge serial_shift_clock) disable iff (!RST_B)
      rout_oe |-> sout_oe &&
        ($past(stream_output_gate, 2) || $past(stream_output_gate, 3));
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("Stream enable without gate pin");
endmodule
